/* hw/framer_pkg.sv */
package framer_pkg;
  localparam int          PKT_BYTES_DEF = 64;
  localparam int          CRC_BYTES     = 4;
  localparam logic [31:0] CRC_POLY      = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT      = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_XOR_OUT   = 32'hFFFFFFFF;
  localparam logic [7:0]  PAD_BYTE      = 8'h00;
  localparam logic [7:0]  SCR_SEED      = 8'h5D;
  localparam logic [2:0]  QAM_4         = 3'h0;
  localparam logic [2:0]  QAM_16        = 3'h1;
  localparam logic [2:0]  QAM_64        = 3'h2;
  localparam logic [2:0]  QAM_256       = 3'h3;

  typedef enum logic [1:0] {TX_IDLE, TX_BODY, TX_CRC} tx_state_t;

  // Reflected byte-wise CRC-32 step
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ b[i]) begin
        r = (r >> 1) ^ 32'hEDB88320;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  // Additive scrambler x^7+x^4+1 over one byte; returns new state in [14:8], mask in [7:0]
  function automatic logic [14:0] scr_step(input logic [6:0] s);
    logic [6:0] r;
    logic [7:0] m;
    r = s;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m[i] = r[6] ^ r[3];
      r = {r[5:0], m[i]};
    end
    return {r, m};
  endfunction

  function automatic logic [3:0] qam_bits(input logic [2:0] q);
    return {q[1:0], 1'b0} + 4'h2;
  endfunction
endpackage

/* hw/mac_packet_framer_checker.sv */
`timescale 1ns/1ps
// Functional notes
// - Packet starts with header byte holding payload byte count.
// - Payload bytes follow in order, then padding fills the packet.
// - A 32-bit CRC is the final field of every packet.
// - Receiver validates each frame by its IEEE 32-bit CRC.
// - Receiver validates packets and extracts payload toward the host.
// - Without host payload, zero-padded packets are still generated on demand.
// - Transmit path scrambles, groups bits into symbols, and reorders.
// - Receive path reorders, packs bytes, descrambles before validation.
// - Modulation selectable from 4-QAM up to 256-QAM.
module mac_packet_framer_checker
  import framer_pkg::*;
#(
  parameter int PKT_BYTES = PKT_BYTES_DEF
) (
  input  wire logic       CORE_CLK_I,
  input  wire logic       NRST_I,
  input  wire logic [2:0] QAM_SEL_I,
  input  wire logic       TX_REQ_I,
  input  wire logic       TX_SRC_VALID_I,
  input  wire logic [7:0] TX_SRC_DATA_I,
  input  wire logic       TX_SRC_LAST_I,
  output logic            TX_SRC_READY_O,
  output logic            TX_SYM_VALID_O,
  output logic [7:0]      TX_SYM_O,
  output logic            TX_BUSY_O,
  input  wire logic       RX_SYM_VALID_I,
  input  wire logic [7:0] RX_SYM_I,
  input  wire logic       RX_SOF_I,
  output logic            RX_PAY_VALID_O,
  output logic [7:0]      RX_PAY_DATA_O,
  output logic            RX_DONE_O,
  output logic            RX_CRC_ERR_O,
  output logic [15:0]     RX_ERR_COUNT_O
);
  localparam int BODY = PKT_BYTES - CRC_BYTES;

  // Positions and the header are one byte wide, and the CRC needs room after the header
  if (PKT_BYTES < 6 || PKT_BYTES > 255) begin : g_bad_size
    $error("PKT_BYTES out of range");
  end

  typedef struct packed {
    tx_state_t   tst;
    logic [7:0]  tpos;
    logic        src_done;
    logic [31:0] tcrc;
    logic [6:0]  tscr;
    logic [15:0] tshift;
    logic [4:0]  tcnt;
    logic        sym_v;
    logic [7:0]  sym;
    logic [2:0]  qam;
    logic [15:0] rshift;
    logic [4:0]  rcnt;
    logic [6:0]  rscr;
    logic [7:0]  rpos;
    logic [7:0]  rlen;
    logic        ract;
    logic [31:0] rcrc;
    logic [PKT_BYTES-1:0][7:0] tbuf;
    logic [PKT_BYTES-1:0][7:0] rbuf;
    logic        pv;
    logic [7:0]  pd;
    logic [7:0]  dpos;
    logic        dact;
    logic        done;
    logic        err;
    logic [15:0] errc;
  } state_t;
  // Separate buffers so a frame may arrive while the next payload is being queued
  state_t s_q, s_d;

  logic [3:0]  bps;
  logic [7:0]  tx_byte;
  logic        tx_take;
  logic [14:0] tsc;
  logic [14:0] rsc;
  logic [7:0]  rx_byte;
  logic [3:0]  rbps;
  logic [3:0]  tw;
  logic [3:0]  rw;

  always_comb begin
    s_d = s_q;
    bps = qam_bits(s_q.qam);
    rbps = qam_bits(s_q.qam);
    // A symbol never spans two bytes: the 6-bit mode ends each byte with a short one
    tw = (s_q.tcnt < 5'(bps)) ? s_q.tcnt[3:0] : bps;
    rw = ((4'h8 - {1'b0, s_q.rcnt[2:0]}) < rbps) ? 4'h8 - {1'b0, s_q.rcnt[2:0]} : rbps;
    tsc = scr_step(s_q.tscr);
    rsc = scr_step(s_q.rscr);
    tx_byte = PAD_BYTE;
    tx_take = 1'b0;
    rx_byte = 8'h00;
    s_d.sym_v = 1'b0;
    s_d.pv = 1'b0;
    s_d.done = 1'b0;
    // Scheme changes only between packets so the grouping stays aligned
    if (s_q.tst == TX_IDLE && s_q.tcnt == 5'h00 && !s_q.ract) begin
      s_d.qam = (QAM_SEL_I <= QAM_256) ? QAM_SEL_I : QAM_4;
    end
    // Symbol grouping: emit a symbol while bits of the current byte remain
    if (s_q.tcnt != 5'h00) begin
      s_d.sym_v = 1'b1;
      // Reorder: bits go out MSB-first of each group
      s_d.sym = 8'(s_q.tshift[15 -: 8] >> (4'h8 - tw));
      s_d.tshift = s_q.tshift << tw;
      s_d.tcnt = s_q.tcnt - 5'(tw);
    end else if (s_q.tst != TX_IDLE) begin
      tx_take = 1'b1;
      unique case (s_q.tst)
        TX_BODY: begin
          if (s_q.tpos == 8'h00) begin
            tx_byte = s_q.tbuf[0];
          end else begin
            tx_byte = s_q.tbuf[s_q.tpos];
          end
          s_d.tcrc = crc_byte(s_q.tcrc, tx_byte);
          if (s_q.tpos == 8'(BODY - 1)) begin
            s_d.tst = TX_CRC;
            s_d.tpos = 8'h00;
          end else begin
            s_d.tpos = s_q.tpos + 8'h01;
          end
        end
        TX_CRC: begin
          tx_byte = 8'((s_q.tcrc ^ CRC_XOR_OUT) >> {s_q.tpos[1:0], 3'b000});
          s_d.tpos = s_q.tpos + 8'h01;
          if (s_q.tpos == 8'(CRC_BYTES - 1)) begin
            // Position restarts so the next payload count begins from zero
            s_d.tst = TX_IDLE;
            s_d.tpos = 8'h00;
          end
        end
        default: ;
      endcase
      tsc = scr_step(s_q.tscr);
      s_d.tscr = tsc[14:8];
      s_d.tshift = {tx_byte ^ tsc[7:0], 8'h00};
      s_d.tcnt = 5'h08;
    end
    // Collect payload while idle; start on demand even with no payload
    if (s_q.tst == TX_IDLE && s_q.tcnt == 5'h00) begin
      if (TX_SRC_VALID_I && !s_q.src_done && s_q.tpos < 8'(BODY - 1)) begin
        s_d.tbuf[s_q.tpos + 8'h01] = TX_SRC_DATA_I;
        s_d.tpos = s_q.tpos + 8'h01;
        s_d.src_done = TX_SRC_LAST_I || (s_q.tpos == 8'(BODY - 2));
      end else if (TX_REQ_I) begin
        for (int i = 1; i < BODY; i++) begin
          if (i > s_q.tpos) s_d.tbuf[i] = PAD_BYTE;
        end
        s_d.tbuf[0] = s_q.tpos;
        s_d.tst = TX_BODY;
        s_d.tpos = 8'h00;
        s_d.src_done = 1'b0;
        s_d.tcrc = CRC_INIT;
        s_d.tscr = SCR_SEED[6:0];
      end
    end
    // Receive: pack demapped symbol bits into bytes, then descramble
    if (RX_SOF_I) begin
      s_d.ract = 1'b1;
      s_d.rcnt = 5'h00;
      s_d.rpos = 8'h00;
      s_d.rcrc = CRC_INIT;
      s_d.rscr = SCR_SEED[6:0];
    end else if (s_q.ract && RX_SYM_VALID_I) begin
      s_d.rshift = (s_q.rshift << rw) | 16'(RX_SYM_I & ((8'h01 << rw) - 8'h01));
      s_d.rcnt = s_q.rcnt + 5'(rw);
    end
    if (s_q.ract && !RX_SOF_I && s_q.rcnt >= 5'h08) begin
      rx_byte = 8'(s_q.rshift >> (s_q.rcnt - 5'h08)) ^ rsc[7:0];
      s_d.rscr = rsc[14:8];
      s_d.rcnt = (RX_SYM_VALID_I ? s_q.rcnt + 5'(rw) : s_q.rcnt) - 5'h08;
      s_d.rpos = s_q.rpos + 8'h01;
      if (s_q.rpos < 8'(BODY)) begin
        s_d.rcrc = crc_byte(s_q.rcrc, rx_byte);
        s_d.rbuf[s_q.rpos] = rx_byte;
        if (s_q.rpos == 8'h00) s_d.rlen = rx_byte;
      end
      if (s_q.rpos == 8'(PKT_BYTES - 1)) begin
        s_d.ract = 1'b0;
        s_d.done = 1'b1;
      end
    end
    // Tail CRC check uses residue of running CRC over the received CRC bytes
    if (s_q.ract && !RX_SOF_I && s_q.rcnt >= 5'h08 && s_q.rpos >= 8'(BODY)) begin
      s_d.rcrc = crc_byte(s_q.rcrc, rx_byte);
    end
    if (s_q.done) begin
      // 0xDEBB20E3 is the CRC-32 residue after running over a good FCS
      s_d.err = (s_q.rcrc != 32'hDEBB20E3);
      if (s_q.rcrc != 32'hDEBB20E3) begin
        s_d.errc = s_q.errc + 16'h0001;
      end else begin
        s_d.dact = (s_q.rlen != 8'h00);
        s_d.dpos = 8'h01;
      end
    end
    if (s_q.dact) begin
      s_d.pv = 1'b1;
      s_d.pd = s_q.rbuf[s_q.dpos];
      s_d.dpos = s_q.dpos + 8'h01;
      if (s_q.dpos == s_q.rlen || s_q.dpos == 8'(BODY - 1)) s_d.dact = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      s_q <= '{tst: TX_IDLE, tcrc: CRC_INIT, rcrc: CRC_INIT, tscr: SCR_SEED[6:0],
               rscr: SCR_SEED[6:0], default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign TX_SRC_READY_O = (s_q.tst == TX_IDLE) && (s_q.tcnt == 5'h00) && !s_q.src_done &&
                          (s_q.tpos < 8'(BODY - 1));
  assign TX_SYM_VALID_O = s_q.sym_v;
  assign TX_SYM_O       = s_q.sym;
  assign TX_BUSY_O      = (s_q.tst != TX_IDLE) || (s_q.tcnt != 5'h00);
  assign RX_PAY_VALID_O = s_q.pv;
  assign RX_PAY_DATA_O  = s_q.pd;
  assign RX_DONE_O      = s_q.done;
  assign RX_CRC_ERR_O   = s_q.err;
  assign RX_ERR_COUNT_O = s_q.errc;
endmodule

/* testbench/mac_packet_framer_checker_chk.sv */
`timescale 1ns/1ps
module framer_chk
  import framer_pkg::*;
(
  input wire logic        CORE_CLK_I,
  input wire logic        NRST_I,
  input wire logic [2:0]  QAM_SEL_I,
  input wire logic        TX_REQ_I,
  input wire logic        TX_SRC_VALID_I,
  input wire logic        TX_SRC_READY_O,
  input wire logic        TX_SYM_VALID_O,
  input wire logic [7:0]  TX_SYM_O,
  input wire logic        TX_BUSY_O,
  input wire logic        RX_PAY_VALID_O,
  input wire logic        RX_DONE_O,
  input wire logic        RX_CRC_ERR_O,
  input wire logic [15:0] RX_ERR_COUNT_O
);
  logic [7:0] lim;
  assign lim = (QAM_SEL_I == QAM_16) ? 8'h0F : (QAM_SEL_I == QAM_64) ? 8'h3F :
               (QAM_SEL_I == QAM_256) ? 8'hFF : 8'h03;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  reset_quiet_a: assert property (disable iff (1'b0)
    !NRST_I |-> !TX_SYM_VALID_O && !RX_DONE_O && !RX_PAY_VALID_O) else $error("active in reset");
  first_symbol_a: assert property (TX_REQ_I && !TX_BUSY_O &&
    !(TX_SRC_VALID_I && TX_SRC_READY_O) |-> ##3 TX_SYM_VALID_O) else $error("late symbol");
  busy_refuse_a: assert property (TX_BUSY_O |-> !TX_SRC_READY_O)
    else $error("ready while busy");
  symbol_width_a: assert property (TX_SYM_VALID_O |-> (TX_SYM_O & ~lim) == 8'h00)
    else $error("symbol too wide");
  byte_gap_a: assert property (TX_SYM_VALID_O && QAM_SEL_I == QAM_256 |=> !TX_SYM_VALID_O)
    else $error("no load gap");
  err_timing_a: assert property ($changed(RX_CRC_ERR_O) |-> $past(RX_DONE_O))
    else $error("status moved off frame end");
  count_step_a: assert property ($changed(RX_ERR_COUNT_O) |->
    RX_ERR_COUNT_O == $past(RX_ERR_COUNT_O) + 16'h0001 && RX_CRC_ERR_O) else $error("bad count");
  bad_no_pay_a: assert property (RX_PAY_VALID_O |-> !RX_CRC_ERR_O)
    else $error("payload from bad frame");
  pay_wait_a: assert property (RX_DONE_O |-> !RX_PAY_VALID_O ##1 !RX_PAY_VALID_O)
    else $error("payload before check");
endmodule
bind mac_packet_framer_checker framer_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I),
  .QAM_SEL_I(QAM_SEL_I), .TX_REQ_I(TX_REQ_I), .TX_SRC_VALID_I(TX_SRC_VALID_I),
  .TX_SRC_READY_O(TX_SRC_READY_O), .TX_SYM_VALID_O(TX_SYM_VALID_O), .TX_SYM_O(TX_SYM_O),
  .TX_BUSY_O(TX_BUSY_O), .RX_PAY_VALID_O(RX_PAY_VALID_O), .RX_DONE_O(RX_DONE_O),
  .RX_CRC_ERR_O(RX_CRC_ERR_O), .RX_ERR_COUNT_O(RX_ERR_COUNT_O));

/* testbench/phy_loop_model.sv */
`timescale 1ns/1ps
// Symbol loopback standing in for the modem chain; marks frame start on busy rise
module phy_loop_model (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       busy_i,
  input  wire logic       sym_valid_i,
  input  wire logic [7:0] sym_i,
  input  wire logic       corrupt_i,
  output logic            sof_o,
  output logic            valid_o,
  output logic [7:0]      data_o
);
  logic busy_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_q <= 1'b0;
      sof_o <= 1'b0;
      valid_o <= 1'b0;
      data_o <= 8'h00;
    end else begin
      busy_q <= busy_i;
      sof_o <= busy_i && !busy_q;
      valid_o <= sym_valid_i;
      // Idle bus shows the inverse so stale data is never mistaken for a symbol
      data_o <= sym_valid_i ? (sym_i ^ {7'h00, corrupt_i}) : ~data_o;
    end
  end
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  import framer_pkg::*;
  localparam int PB = 16;
  logic clk = 1'b0, nrst = 1'b1, req = 1'b0, sv = 1'b0, sl = 1'b0, bad = 1'b0;
  logic [2:0] qs = 3'h0;
  logic [7:0] sd = 8'h00, ts, rs, pd;
  logic rdy, tsv, busy, sof, rsv, pv, done, cerr;
  logic [15:0] ecnt, fails = 16'h0000;
  logic [31:0] rng = 32'h8434;
  logic [7:0] pay [$], got [$];
  int errors = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  mac_packet_framer_checker #(.PKT_BYTES(PB)) uut (.CORE_CLK_I(clk), .NRST_I(nrst),
    .QAM_SEL_I(qs), .TX_REQ_I(req), .TX_SRC_VALID_I(sv), .TX_SRC_DATA_I(sd), .TX_SRC_LAST_I(sl),
    .TX_SRC_READY_O(rdy), .TX_SYM_VALID_O(tsv), .TX_SYM_O(ts), .TX_BUSY_O(busy),
    .RX_SYM_VALID_I(rsv), .RX_SYM_I(rs), .RX_SOF_I(sof), .RX_PAY_VALID_O(pv),
    .RX_PAY_DATA_O(pd), .RX_DONE_O(done), .RX_CRC_ERR_O(cerr), .RX_ERR_COUNT_O(ecnt));
  phy_loop_model far (.clk_i(clk), .nrst_i(nrst), .busy_i(busy), .sym_valid_i(tsv),
    .sym_i(ts), .corrupt_i(bad), .sof_o(sof), .valid_o(rsv), .data_o(rs));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Symbols per byte; the 6-bit mode spends a short second symbol on the remainder
  function automatic int spb(input logic [2:0] q);
    return (q == QAM_256) ? 1 : (q == QAM_16 || q == QAM_64) ? 2 : 4;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic run_pkt(input int n, input logic [2:0] q, input logic b);
    int k, nsym;
    logic seen;
    pay = {};
    got = {};
    nsym = 0;
    seen = 1'b0;
    qs = q;
    bad = b;
    for (int i = 0; i < n; i++) begin
      rng = xs(rng);
      pay.push_back(rng[7:0]);
      sv = 1'b1;
      sd = rng[7:0];
      sl = (i == n - 1);
      #1;
      k = 0;
      while (rdy !== 1'b1 && k < 50) begin
        @(negedge clk);
        k++;
      end
      chk(rdy, 1, "source ready");
      if (k == 50) tally_and_finish();
      @(negedge clk);
    end
    sv = 1'b0;
    sl = 1'b0;
    if (n == PB - 5) chk(rdy, 0, "ready when full");
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    k = 0;
    while (k < 900) begin
      @(negedge clk);
      k++;
      nsym += (tsv === 1'b1);
      if (pv === 1'b1) got.push_back(pd);
      if (done === 1'b1) begin
        seen = 1'b1;
        k = 870;
      end
    end
    chk(seen, 1, "frame end");
    if (!seen) tally_and_finish();
    else begin
      chk(nsym, PB * spb(q), "symbol count");
      chk(cerr, b, "crc status");
      chk(got.size(), b ? 0 : n, "payload length");
      for (int i = 0; i < got.size() && i < n; i++) chk(got[i], pay[i], "payload");
      fails += {15'h0000, b};
      chk(ecnt, fails, "fail count");
      $display("packet of %0d bytes mode %0d done", n, q);
    end
  endtask
  initial begin
    // Reset lands before the first edge so no sample ever sees unknown outputs
    #1;
    nrst = 1'b0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    run_pkt(0, QAM_16, 1'b0);
    run_pkt(PB - 5, QAM_256, 1'b0);
    run_pkt(3, QAM_64, 1'b1);
    for (int i = 0; i < 14; i++) begin
      rng = xs(rng);
      run_pkt(rng[15:0] % (PB - 4), 3'(i % 6), (i % 5) == 4);
    end
    tally_and_finish();
  end
endmodule
